// *** design/cmcr_ctrl.sv ***
// Purpose: Main control register, mode decode, cache policy and FPU trap gating.
// Assumes: Single core clock; pins arrive asynchronous and are filtered here.
// Notes:   Decision outputs are combinational qualifiers of same-cycle requests.
//
// Operation
// - Decode real, protected, paged protected modes
// - Paging without protection raises fault, code zero
// - Fill without write-through raises fault
// - Install fill only if allowed, pin low, cacheable
// - Reset clears fill_allow
// - Write-through sends all writes, honours invalidates
// - No write-through: hits stay local, invalidates ignored
// - Alignment faults only when align_gate set
// - ro_guard faults read-only writes at every level
// - Route bit picks vector 16 or external
// - Error pin active on every unmasked fault
// - External route: freeze unless ignore input active
// - Control instructions freeze only in the frozen state; wait does
// - Internal route: interrupt 16, ignore input disregarded
// - Task switch sets switch_flag
// - switch_flag traps floating point to vector 7
// - fpu_trap_all traps floating point, not wait
// - Wait traps only with switch_flag and wait_watch
// - Low word alias touches only bits 15..0
// - protect_on lives at bit 0
// - wait_watch at bit 1 affects wait only
// - Low word load keeps coproc_type_bit, route
// - Only privilege level 0 may access
`timescale 1ns/100ps
module cmcr_ctrl (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_wr_full,
  input  wire logic        i_wr_low,
  input  wire logic        i_rd_full,
  input  wire logic        i_rd_low,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [1:0]  i_cpl,
  output logic      [31:0] o_rd_data,
  output logic             o_rd_valid,
  output logic             o_gp_fault,
  output logic      [15:0] o_gp_err_code,
  output logic      [2:0]  o_mode,
  output logic      [31:0] o_ctrl_word,
  input  wire logic        i_miss_line,
  input  wire logic        i_fill_ok_pin_n,
  input  wire logic        i_page_uncache,
  output logic             o_fill_install,
  input  wire logic        i_write_req,
  input  wire logic        i_write_hit,
  output logic             o_write_to_bus,
  input  wire logic        i_inval_cycle,
  input  wire logic        i_inval_hit,
  output logic             o_inval_line,
  input  wire logic        i_misaligned,
  input  wire logic        i_align_flag,
  output logic             o_align_fault,
  input  wire logic        i_write_ro_page,
  output logic             o_ro_fault,
  input  wire logic        i_task_switch,
  input  wire logic        i_unmasked_fpu_fault,
  input  wire logic        i_fpu_err_clear,
  input  wire logic        i_ext_intr_taken,
  input  wire logic        i_fpu_fault_ignore_in_n,
  output logic             o_fpu_fault_out_n,
  input  wire logic        i_ins_valid,
  input  wire logic [1:0]  i_ins_kind,
  output logic             o_ins_go,
  output logic             o_fpu_absent_fault,
  output logic             o_fpu_int16,
  output logic             o_fpu_freeze,
  output logic      [7:0]  o_trap_vector
);

  logic [31:0]              ctrl;
  logic [31:0]              next_ctrl;
  logic                     wr_any;
  logic                     priv_ok;
  logic                     bad_mode;
  logic                     bad_cache;
  logic                     wr_fault;
  logic                     rd_fault;
  logic [2:0]               fill_sync;
  logic                     fill_pin_n;
  logic [2:0]               ign_sync;
  logic                     ignore_act;
  cmcr_pkg::cmcr_fe_e       fe_state;
  cmcr_pkg::cmcr_fe_e       next_fe_state;
  logic                     fe_pending;
  logic                     is_fp;
  logic                     is_wait;
  logic                     trap7;
  logic                     err_hit;

  // Shared bit pick, used for every control field that the logic reads
  function automatic logic cbit(input logic [31:0] w, input int unsigned pos);
    cbit = w[pos];
  endfunction : cbit

  // ---------------- Register access ----------------
  assign wr_any  = i_wr_full | i_wr_low;
  assign priv_ok = (i_cpl == 2'h0);

  always_comb begin
    next_ctrl = ctrl;
    if (i_wr_full) begin
      next_ctrl = i_wr_data & cmcr_pkg::CMCR_WR_MASK;
    end else if (i_wr_low) begin
      next_ctrl = (ctrl & ~cmcr_pkg::CMCR_LOW_MASK)
                | (i_wr_data & cmcr_pkg::CMCR_LOW_MASK & cmcr_pkg::CMCR_WR_MASK);
    end
  end

  assign bad_mode  = cbit(next_ctrl, cmcr_pkg::BIT_PAGING_ON)
                   & ~cbit(next_ctrl, cmcr_pkg::BIT_PROTECT_ON);
  assign bad_cache = cbit(next_ctrl, cmcr_pkg::BIT_FILL_ALLOW)
                   & ~cbit(next_ctrl, cmcr_pkg::BIT_WRITE_THRU);
  assign wr_fault  = wr_any & (~priv_ok | bad_mode | bad_cache);
  assign rd_fault  = (i_rd_full | i_rd_low) & ~priv_ok;

  // A refused load leaves the register as it was; a task switch sets
  // switch_flag and wins over a same-cycle software clear.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= cmcr_pkg::CMCR_RESET;
    end else begin
      if (wr_any && !wr_fault) begin
        ctrl <= next_ctrl;
      end
      if (i_task_switch) begin
        ctrl[cmcr_pkg::BIT_SWITCH_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gp_fault    <= 1'b0;
      o_gp_err_code <= 16'h0000;
    end else begin
      o_gp_fault <= wr_fault | rd_fault;
      if (~priv_ok) begin
        o_gp_err_code <= cmcr_pkg::GP_CODE_PRIV;
      end else if (bad_mode) begin
        o_gp_err_code <= cmcr_pkg::GP_CODE_MODE;
      end else begin
        o_gp_err_code <= cmcr_pkg::GP_CODE_CACHE;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data  <= 32'h0000_0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= (i_rd_full | i_rd_low) & priv_ok;
      if (i_rd_full && priv_ok) begin
        o_rd_data <= ctrl;
      end else if (i_rd_low && priv_ok) begin
        o_rd_data <= {16'h0000, ctrl[15:0]};
      end
    end
  end

  assign o_ctrl_word = ctrl;

  // ---------------- Mode decode ----------------
  always_comb begin
    case ({cbit(ctrl, cmcr_pkg::BIT_PAGING_ON), cbit(ctrl, cmcr_pkg::BIT_PROTECT_ON)})
      2'b01:   o_mode = cmcr_pkg::CMCR_MODE_PROT;
      2'b11:   o_mode = cmcr_pkg::CMCR_MODE_PAGED;
      default: o_mode = cmcr_pkg::CMCR_MODE_REAL;
    endcase
  end

  // ---------------- Pin filters ----------------
  // Stage 0 feeds stage 1 only; a level counts once stages 1 and 2 agree.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill_sync  <= 3'h7;
      fill_pin_n <= 1'b1;
    end else begin
      fill_sync <= {fill_sync[1:0], i_fill_ok_pin_n};
      if (fill_sync[1] == fill_sync[2]) begin
        fill_pin_n <= fill_sync[2];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ign_sync   <= 3'h7;
      ignore_act <= 1'b0;
    end else begin
      ign_sync <= {ign_sync[1:0], i_fpu_fault_ignore_in_n};
      if (ign_sync[1] == ign_sync[2]) begin
        ignore_act <= ~ign_sync[2];
      end
    end
  end

  // ---------------- Cache policy ----------------
  assign o_fill_install = i_miss_line & cbit(ctrl, cmcr_pkg::BIT_FILL_ALLOW)
                        & ~fill_pin_n & ~i_page_uncache;
  // Hits go out only with write-through; misses always do
  assign o_write_to_bus = i_write_req
                        & (~i_write_hit | cbit(ctrl, cmcr_pkg::BIT_WRITE_THRU));
  assign o_inval_line   = i_inval_cycle & i_inval_hit
                        & cbit(ctrl, cmcr_pkg::BIT_WRITE_THRU);

  // ---------------- Fault gating ----------------
  assign o_align_fault = i_misaligned & i_align_flag
                       & cbit(ctrl, cmcr_pkg::BIT_ALIGN_GATE);
  assign o_ro_fault    = i_write_ro_page
                       & (cbit(ctrl, cmcr_pkg::BIT_RO_GUARD) | (i_cpl == 2'h3));

  // ---------------- Floating point error reporting ----------------
  assign fe_pending = (fe_state != cmcr_pkg::CMCR_FE_IDLE);

  always_comb begin
    next_fe_state = fe_state;
    case (fe_state)
      cmcr_pkg::CMCR_FE_IDLE: begin
        if (i_unmasked_fpu_fault) begin
          next_fe_state = cmcr_pkg::CMCR_FE_PEND;
        end
      end
      cmcr_pkg::CMCR_FE_PEND: begin
        if (i_fpu_err_clear && !i_unmasked_fpu_fault) begin
          next_fe_state = cmcr_pkg::CMCR_FE_IDLE;
        end else if (o_fpu_freeze) begin
          next_fe_state = cmcr_pkg::CMCR_FE_FROZEN;
        end
      end
      cmcr_pkg::CMCR_FE_FROZEN: begin
        // The handler reached through the external controller unfreezes us
        if (i_ext_intr_taken || ignore_act) begin
          next_fe_state = cmcr_pkg::CMCR_FE_PEND;
        end
        if (i_fpu_err_clear && !i_unmasked_fpu_fault) begin
          next_fe_state = cmcr_pkg::CMCR_FE_IDLE;
        end
      end
      default: next_fe_state = cmcr_pkg::CMCR_FE_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fe_state          <= cmcr_pkg::CMCR_FE_IDLE;
      o_fpu_fault_out_n <= 1'b1;
    end else begin
      fe_state          <= next_fe_state;
      o_fpu_fault_out_n <= ~(next_fe_state != cmcr_pkg::CMCR_FE_IDLE);
    end
  end

  // ---------------- Instruction gate ----------------
  assign is_fp   = i_ins_valid & ((i_ins_kind == cmcr_pkg::CMCR_INS_FP)
                 | (i_ins_kind == cmcr_pkg::CMCR_INS_CTRL));
  assign is_wait = i_ins_valid & (i_ins_kind == cmcr_pkg::CMCR_INS_WAIT);

  assign trap7 = (is_fp & (cbit(ctrl, cmcr_pkg::BIT_FPU_TRAP)
                         | cbit(ctrl, cmcr_pkg::BIT_SWITCH_FLAG)))
               | (is_wait & cbit(ctrl, cmcr_pkg::BIT_SWITCH_FLAG)
                          & cbit(ctrl, cmcr_pkg::BIT_WAIT_WATCH));
  // Non-waiting control instructions bypass a pending error
  assign err_hit = fe_pending & ~trap7 & i_ins_valid
                 & ((i_ins_kind == cmcr_pkg::CMCR_INS_FP) | is_wait);

  assign o_fpu_absent_fault = trap7;
  assign o_fpu_int16  = err_hit & cbit(ctrl, cmcr_pkg::BIT_FPU_ROUTE);
  assign o_fpu_freeze = (err_hit & ~cbit(ctrl, cmcr_pkg::BIT_FPU_ROUTE)
                      & ~ignore_act)
                      | (fe_state == cmcr_pkg::CMCR_FE_FROZEN);
  assign o_ins_go     = i_ins_valid & ~trap7 & ~o_fpu_int16 & ~o_fpu_freeze;
  assign o_trap_vector = trap7 ? cmcr_pkg::VEC_FPU_ABSENT
                       : (o_fpu_int16 ? cmcr_pkg::VEC_FPU_ERROR : 8'h00);

  // ---------------- Checks ----------------
  chk_mode_decode: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ctrl[31] && ctrl[0]) |-> (o_mode == cmcr_pkg::CMCR_MODE_PAGED))
    else $error("paged mode not decoded");
  chk_bad_mode_fault: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_wr_full && i_wr_data[31] && !i_wr_data[0] && !i_task_switch) |=> (o_gp_fault && o_gp_err_code == 16'h0000
      && ctrl == $past(ctrl)))
    else $error("paging without protection accepted");
  chk_bad_cache_fault: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_wr_full && i_wr_data[30] && !i_wr_data[29]) |=> (o_gp_fault && ctrl[30] == $past(ctrl[30])))
    else $error("invalid cache setting accepted");
  chk_fill_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_fill_install |-> (ctrl[30] && !i_page_uncache && !fill_pin_n))
    else $error("fill installed while disallowed");
  chk_write_hit_local: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_write_req && i_write_hit && !ctrl[29]) |-> (!o_write_to_bus && !o_inval_line))
    else $error("write hit left chip without write-through");
  chk_align_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_align_fault |-> ctrl[18])
    else $error("alignment fault while gated off");
  chk_fpu_fault_out_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_unmasked_fpu_fault |=> !o_fpu_fault_out_n)
    else $error("error pin not driven after fault");
  chk_ctrl_no_freeze: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_ins_valid && i_ins_kind == cmcr_pkg::CMCR_INS_CTRL && fe_state == cmcr_pkg::CMCR_FE_PEND
      && !trap7) |-> o_ins_go)
    else $error("control instruction frozen");
  chk_route_int16: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (err_hit && ctrl[5]) |-> (o_fpu_int16 && !o_fpu_freeze && o_trap_vector == 8'h10))
    else $error("internal route did not raise vector 16");
  chk_switch_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_task_switch |=> ctrl[3])
    else $error("task switch did not set switch_flag");
  chk_wait_trap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    is_wait |-> (o_fpu_absent_fault == (ctrl[3] && ctrl[1])))
    else $error("wait trap decode wrong");
  chk_low_keep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_wr_low && !i_wr_full && !i_task_switch) |=> (ctrl[31:16] == $past(ctrl[31:16])
      && ctrl[5:4] == $past(ctrl[5:4])))
    else $error("low word load touched protected bits");
  chk_priv_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ((i_wr_full || i_wr_low) && i_cpl != 2'h0 && !i_task_switch) |=> (o_gp_fault && $stable(ctrl)))
    else $error("unprivileged access accepted");
  chk_mode_prot: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (!ctrl[31] && ctrl[0]) |-> (o_mode == cmcr_pkg::CMCR_MODE_PROT))
    else $error("protected mode not decoded");
  chk_mode_real: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !ctrl[0] |-> (o_mode == cmcr_pkg::CMCR_MODE_REAL))
    else $error("real mode not decoded");
  chk_write_thru_all: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_write_req && ctrl[29]) |-> o_write_to_bus)
    else $error("write kept local under write-through");
  chk_inval_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_inval_cycle && i_inval_hit) |-> (o_inval_line == ctrl[29]))
    else $error("invalidate handling wrong");
  chk_ro_guard: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_write_ro_page && (ctrl[16] || i_cpl == 2'h3)) |-> o_ro_fault)
    else $error("read-only write not faulted");
  chk_ro_allow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_write_ro_page && !ctrl[16] && i_cpl != 2'h3) |-> !o_ro_fault)
    else $error("supervisor read-only write faulted");
  chk_trap_all: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (is_fp && (ctrl[2] || ctrl[3])) |-> (o_fpu_absent_fault && !o_ins_go && o_trap_vector == 8'h07))
    else $error("floating point trap 7 missing");
  chk_freeze_ext: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (err_hit && !ctrl[5] && !ignore_act) |-> (o_fpu_freeze && !o_ins_go))
    else $error("external route did not freeze");
  chk_ignore_go: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (err_hit && !ctrl[5] && ignore_act && fe_state == cmcr_pkg::CMCR_FE_PEND) |-> o_ins_go)
    else $error("ignored error still held instruction");

endmodule : cmcr_ctrl

// *** shared/cmcr_pkg.sv ***
// Purpose: Shared constants for the processor main control register block.
// Assumes: 32-bit control word; bit positions fixed by the architecture.
// Notes:   Offsets here are bit positions, since the register has no bus address.
package cmcr_pkg;

  localparam int unsigned CMCR_W          = 32;
  localparam int unsigned CMCR_LOW_W      = 16;

  // Field positions of main_ctrl_reg
  localparam int unsigned BIT_PAGING_ON   = 31;
  localparam int unsigned BIT_FILL_ALLOW  = 30;
  localparam int unsigned BIT_WRITE_THRU  = 29;
  localparam int unsigned BIT_ALIGN_GATE  = 18;
  localparam int unsigned BIT_RO_GUARD    = 16;
  localparam int unsigned BIT_FPU_ROUTE   = 5;
  localparam int unsigned BIT_COPROC_TYPE = 4;
  localparam int unsigned BIT_SWITCH_FLAG = 3;
  localparam int unsigned BIT_FPU_TRAP    = 2;
  localparam int unsigned BIT_WAIT_WATCH  = 1;
  localparam int unsigned BIT_PROTECT_ON  = 0;

  // Implemented bits; all others read as zero
  localparam logic [31:0] CMCR_WR_MASK    = 32'hE005_003F;
  // Low-word loads may not touch coproc_type_bit or fpu_err_route
  localparam logic [31:0] CMCR_LOW_MASK   = 32'h0000_FFCF;
  localparam logic [31:0] CMCR_RESET      = 32'h0000_0000;

  // Error codes pushed with the general protection fault
  localparam logic [15:0] GP_CODE_MODE    = 16'h0000;
  localparam logic [15:0] GP_CODE_CACHE   = 16'h0000;
  localparam logic [15:0] GP_CODE_PRIV    = 16'h0000;

  localparam logic [7:0]  VEC_FPU_ABSENT  = 8'h07;
  localparam logic [7:0]  VEC_FPU_ERROR   = 8'h10;

  // Kind of the instruction presented to the floating point gate
  typedef enum logic [1:0] {
    CMCR_INS_FP    = 2'h0,
    CMCR_INS_CTRL  = 2'h1,
    CMCR_INS_WAIT  = 2'h2,
    CMCR_INS_OTHER = 2'h3
  } cmcr_ins_e;

  // Operating modes, one-hot
  typedef enum logic [2:0] {
    CMCR_MODE_REAL  = 3'h1,
    CMCR_MODE_PROT  = 3'h2,
    CMCR_MODE_PAGED = 3'h4
  } cmcr_mode_e;

  // Floating point error reporting state, one-hot
  typedef enum logic [2:0] {
    CMCR_FE_IDLE   = 3'h1,
    CMCR_FE_PEND   = 3'h2,
    CMCR_FE_FROZEN = 3'h4
  } cmcr_fe_e;

endpackage : cmcr_pkg

// *** sim/cmcr_ctrl_tb.sv ***
// Purpose: Self-checking bench for the main control register block.
// Assumes: Expectations come from a bench-side copy of the control word.
// Notes:   Pin inputs are held 4 edges before checks, since the design filters them through 3 sync flops and a registered output.
`timescale 1ns/100ps
module cmcr_ctrl_tb;
  logic        i_core_clk, i_reset_n, i_wr_full, i_wr_low, i_rd_full, i_rd_low;
  logic [31:0] i_wr_data;
  logic [1:0]  i_cpl, i_ins_kind;
  logic        i_miss_line, i_fill_ok_pin_n, i_page_uncache, i_write_req, i_write_hit, i_inval_cycle;
  logic        i_inval_hit, i_misaligned, i_align_flag, i_write_ro_page, i_task_switch, i_unmasked_fpu_fault;
  logic        i_fpu_err_clear, i_ext_intr_taken, i_fpu_fault_ignore_in_n, i_ins_valid;
  logic [31:0] o_rd_data, o_ctrl_word;
  logic [15:0] o_gp_err_code;
  logic [2:0]  o_mode;
  logic [7:0]  o_trap_vector;
  logic        o_rd_valid, o_gp_fault, o_fill_install, o_write_to_bus, o_inval_line, o_align_fault, o_ro_fault;
  logic        o_fpu_fault_out_n, o_ins_go, o_fpu_absent_fault, o_fpu_int16, o_fpu_freeze;
  int          n_errors, num_checks, seed;
  logic [31:0] model;
  logic [1:0]  cur_cpl;

  cmcr_ctrl i_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_wr_full(i_wr_full), .i_wr_low(i_wr_low),
    .i_rd_full(i_rd_full), .i_rd_low(i_rd_low), .i_wr_data(i_wr_data), .i_cpl(i_cpl), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_gp_fault(o_gp_fault), .o_gp_err_code(o_gp_err_code), .o_mode(o_mode),
    .o_ctrl_word(o_ctrl_word), .i_miss_line(i_miss_line), .i_fill_ok_pin_n(i_fill_ok_pin_n),
    .i_page_uncache(i_page_uncache), .o_fill_install(o_fill_install), .i_write_req(i_write_req),
    .i_write_hit(i_write_hit), .o_write_to_bus(o_write_to_bus), .i_inval_cycle(i_inval_cycle),
    .i_inval_hit(i_inval_hit), .o_inval_line(o_inval_line), .i_misaligned(i_misaligned),
    .i_align_flag(i_align_flag), .o_align_fault(o_align_fault), .i_write_ro_page(i_write_ro_page),
    .o_ro_fault(o_ro_fault), .i_task_switch(i_task_switch), .i_unmasked_fpu_fault(i_unmasked_fpu_fault),
    .i_fpu_err_clear(i_fpu_err_clear), .i_ext_intr_taken(i_ext_intr_taken),
    .i_fpu_fault_ignore_in_n(i_fpu_fault_ignore_in_n), .o_fpu_fault_out_n(o_fpu_fault_out_n),
    .i_ins_valid(i_ins_valid), .i_ins_kind(i_ins_kind), .o_ins_go(o_ins_go),
    .o_fpu_absent_fault(o_fpu_absent_fault), .o_fpu_int16(o_fpu_int16), .o_fpu_freeze(o_fpu_freeze),
    .o_trap_vector(o_trap_vector));

  initial begin
    i_core_clk = 1'h0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_flag

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Paging without protection, or fill without write-through, is an illegal word
  function automatic logic bad_word(input logic [31:0] v);
    return (v[31] & ~v[0]) | (v[30] & ~v[29]);
  endfunction : bad_word

  task automatic reg_op(input logic wf, input logic wl, input logic rf, input logic rl,
                        input logic [31:0] d, input logic [1:0] cpl);
    logic [31:0] nv;
    logic        refused;
    nv = wf ? (d & cmcr_pkg::CMCR_WR_MASK) : wl ? (((model & ~cmcr_pkg::CMCR_LOW_MASK) |
         (d & cmcr_pkg::CMCR_LOW_MASK)) & cmcr_pkg::CMCR_WR_MASK) : model;
    refused = (cpl != 2'h0) || ((wf | wl) && bad_word(nv));
    @(posedge i_core_clk);
    i_wr_full <= wf;
    i_wr_low  <= wl & ~wf;
    i_rd_full <= rf;
    i_rd_low  <= rl;
    i_wr_data <= d;
    i_cpl     <= cpl;
    cur_cpl = cpl;
    @(posedge i_core_clk);
    {i_wr_full, i_wr_low, i_rd_full, i_rd_low} <= 4'h0;
    @(negedge i_core_clk);
    chk_flag("gp_fault", refused, o_gp_fault);
    if (refused) chk_word("gp_code", {16'h0000, cmcr_pkg::GP_CODE_MODE}, {16'h0000, o_gp_err_code});
    // A read beside a load sees the word from before the load; only privilege refuses it
    if (rf | rl) chk_flag("rd_valid", cpl == 2'h0, o_rd_valid);
    if ((rf | rl) && cpl == 2'h0) chk_word("rd_data", rf ? model : {16'h0000, model[15:0]}, o_rd_data);
    if (!refused) model = nv;
    chk_word("ctrl_word", model, o_ctrl_word);
    chk_word("mode", {29'h0000_0000, model[31] ? 3'h4 : model[0] ? 3'h2 : 3'h1}, {29'h0000_0000, o_mode});
  endtask : reg_op

  task automatic dec_check();
    logic [12:0] r;
    logic        tr;
    r = 13'($random(seed));
    @(posedge i_core_clk);
    {i_miss_line, i_fill_ok_pin_n, i_page_uncache, i_write_req, i_write_hit, i_inval_cycle, i_inval_hit,
     i_misaligned, i_align_flag, i_write_ro_page, i_ins_valid} <= r[10:0];
    i_ins_kind <= r[12:11];
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk_flag("fill", r[10] & model[30] & ~r[9] & ~r[8], o_fill_install);
    chk_flag("wr_bus", r[7] & (model[29] | ~r[6]), o_write_to_bus);
    chk_flag("inval", r[5] & r[4] & model[29], o_inval_line);
    chk_flag("align", r[3] & r[2] & model[18], o_align_fault);
    chk_flag("ro", r[1] & (model[16] | (cur_cpl == 2'h3)), o_ro_fault);
    // Kinds 0 and 1 are both floating point, so control instructions trap as well
    tr = r[0] & (((r[12] == 1'h0) & (model[2] | model[3])) | ((r[12:11] == 2'h2) & model[3] & model[1]));
    chk_flag("absent", tr, o_fpu_absent_fault);
    chk_word("vector", tr ? 32'h0000_0007 : 32'h0000_0000, {24'h00_0000, o_trap_vector});
    if (r[0]) chk_flag("go", ~tr, o_ins_go);
    @(posedge i_core_clk);
    i_ins_valid <= 1'h0;
  endtask : dec_check

  // Pulses one control input for a single cycle
  task automatic pulse(input int which);
    @(posedge i_core_clk);
    case (which)
      0: i_task_switch <= 1'h1;
      1: i_unmasked_fpu_fault <= 1'h1;
      2: i_fpu_err_clear <= 1'h1;
      default: i_ext_intr_taken <= 1'h1;
    endcase
    @(posedge i_core_clk);
    {i_task_switch, i_unmasked_fpu_fault, i_fpu_err_clear, i_ext_intr_taken} <= 4'h0;
    @(negedge i_core_clk);
  endtask : pulse

  task automatic ins(input logic [1:0] kind, input logic frz, input logic i16, input logic [7:0] vec);
    @(posedge i_core_clk);
    i_ins_valid <= 1'h1;
    i_ins_kind  <= kind;
    @(negedge i_core_clk);
    chk_flag("freeze", frz, o_fpu_freeze);
    chk_flag("int16", i16, o_fpu_int16);
    chk_word("err_vec", {24'h00_0000, vec}, {24'h00_0000, o_trap_vector});
    @(posedge i_core_clk);
    i_ins_valid <= 1'h0;
  endtask : ins

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_errors++;
    test_done();
  end

  initial begin
    logic [31:0] r;
    seed = 72171;
    {n_errors, num_checks} = '0;
    model = cmcr_pkg::CMCR_RESET;
    cur_cpl = 2'h0;
    i_reset_n = 1'h0;
    {i_wr_full, i_wr_low, i_rd_full, i_rd_low, i_wr_data, i_cpl, i_ins_kind} = '0;
    {i_miss_line, i_page_uncache, i_write_req, i_write_hit, i_inval_cycle, i_inval_hit} = '0;
    {i_misaligned, i_align_flag, i_write_ro_page, i_task_switch, i_unmasked_fpu_fault} = '0;
    {i_fpu_err_clear, i_ext_intr_taken, i_ins_valid} = '0;
    {i_fill_ok_pin_n, i_fpu_fault_ignore_in_n} = 2'h3;
    repeat (16) @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    repeat (4) @(negedge i_core_clk);
    chk_word("reset_word", 32'h0000_0000, o_ctrl_word);
    chk_flag("reset_pin", 1'h1, o_fpu_fault_out_n);
    reg_op(1'h1, 1'h0, 1'h0, 1'h0, 32'h8000_0000, 2'h0);
    reg_op(1'h1, 1'h0, 1'h0, 1'h0, 32'h4000_0001, 2'h0);
    reg_op(1'h1, 1'h0, 1'h1, 1'h0, 32'hE005_0033, 2'h0);
    reg_op(1'h0, 1'h1, 1'h0, 1'h1, 32'h0000_000C, 2'h0);
    reg_op(1'h0, 1'h1, 1'h0, 1'h1, 32'h0000_FFCD, 2'h0);
    reg_op(1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h1);
    for (int i = 0; i < 150; i++) begin
      r = $random(seed);
      reg_op(r[1:0] == 2'h0, r[1:0] == 2'h1, r[1:0] == 2'h2, r[1:0] == 2'h3, $random(seed),
             (r[4:2] == 3'h0) ? r[6:5] : 2'h0);
      dec_check();
    end
    pulse(0);
    model[3] = 1'h1;
    chk_word("switch", model, o_ctrl_word);
    dec_check();
    reg_op(1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0021, 2'h0);
    pulse(1);
    chk_flag("fault_pin", 1'h0, o_fpu_fault_out_n);
    @(posedge i_core_clk);
    i_fpu_fault_ignore_in_n <= 1'h0;
    repeat (4) @(posedge i_core_clk);
    ins(2'h0, 1'h0, 1'h1, cmcr_pkg::VEC_FPU_ERROR);
    pulse(2);
    chk_flag("pin_clear", 1'h1, o_fpu_fault_out_n);
    reg_op(1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0001, 2'h0);
    @(posedge i_core_clk);
    i_fpu_fault_ignore_in_n <= 1'h1;
    repeat (4) @(posedge i_core_clk);
    pulse(1);
    ins(2'h1, 1'h0, 1'h0, 8'h00);
    ins(2'h2, 1'h1, 1'h0, 8'h00);
    pulse(3);
    @(posedge i_core_clk);
    i_fpu_fault_ignore_in_n <= 1'h0;
    repeat (4) @(posedge i_core_clk);
    ins(2'h0, 1'h0, 1'h0, 8'h00);
    pulse(2);
    test_done();
  end
endmodule : cmcr_ctrl_tb
